// ===== verilog/tlbc_regs.sv
// Translation-buffer control registers, probe engine and cycle timer.
`timescale 1ns/1ps
module tlbc_regs
   import tlbc_pkg::*;
(
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   // Register move port.
   input wire logic [4:0] reg_num,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Pipeline operations.
   input wire logic instr_retire,
   input wire logic probe_instr,
   input wire logic entry_read_instr,
   input wire logic indexed_write_instr,
   input wire logic random_write_instr,
   input wire logic [VPN2_W-1:0] entry_hi_vpn2,
   output logic busy,
   output logic read_done,
   output logic [VPN2_W-1:0] read_vpn2,
   // Fault capture.
   input wire logic tlb_miss,
   input wire logic addr_err,
   input wire logic [31:0] fault_vaddr,
   // Timer divider select.
   input wire logic [1:0] div_sel,
   // Page attributes.
   output logic even_uncached,
   output logic odd_uncached
);
   typedef enum logic {ST_IDLE, ST_SCAN} tlbc_state_e;

   tlbc_state_e state;
   tlbc_state_e next_state;
   logic probe_fail;
   logic [IDX_W-1:0] index;
   logic [IDX_W-1:0] random;
   logic [IDX_W-1:0] wired;
   logic [31:0] lo_even;
   logic [31:0] lo_odd;
   logic [BASE_W-1:0] ctx_base;
   logic [VPN2_W-1:0] ctx_vpn2;
   logic [MASK_W-1:0] pmask;
   logic [31:0] fault_addr;
   logic [31:0] count;
   logic [3:0] div_cnt;
   logic [IDX_W-1:0] scan_idx;
   logic [IDX_W-1:0] cmp_idx;
   logic cmp_vld;
   logic rd_pend;
   logic [31:0] next_rdata;
   logic [5:0] scan_cycles;
   tlbc_mem_if mbus ();

   wire idle = (state == ST_IDLE);
   wire wr_index = reg_wr && (reg_num == REG_INDEX);
   wire wr_lo_even = reg_wr && (reg_num == REG_LO_EVEN);
   wire wr_lo_odd = reg_wr && (reg_num == REG_LO_ODD);
   wire wr_context = reg_wr && (reg_num == REG_CONTEXT);
   wire wr_pmask = reg_wr && (reg_num == REG_PMASK);
   wire wr_wired = reg_wr && (reg_num == REG_WIRED);
   wire wr_count = reg_wr && (reg_num == REG_COUNT);
   wire probe_go = idle && probe_instr;
   wire read_go = idle && entry_read_instr;
   wire iwrite_go = idle && indexed_write_instr;
   wire rwrite_go = idle && random_write_instr && (random >= wired);
   wire below_wired = (random <= wired);
   wire [IDX_W-1:0] dec_random = below_wired ? IDX_TOP : random - 5'h01;
   wire [VPN2_W-1:0] page_diff = mbus.rd_data.vpn2 ^ entry_hi_vpn2;
   wire [VPN2_W-1:0] cmp_care = ~{{(VPN2_W-MASK_W){1'b0}}, mbus.rd_data.mask};
   wire hit = ((page_diff & cmp_care) == '0);
   wire finish = cmp_vld && (hit || (cmp_idx == IDX_TOP));
   wire [3:0] div_last = (div_sel == DIV_SEL_8) ? DIV8_LAST :
                         (div_sel == DIV_SEL_12) ? DIV12_LAST : DIV16_LAST;
   wire tick = (div_cnt >= div_last);
   wire [2:0] cattr_even = lo_even[CATTR_LSB+2:CATTR_LSB];
   wire [2:0] cattr_odd = lo_odd[CATTR_LSB+2:CATTR_LSB];

   assign mbus.rd_idx = (state == ST_SCAN) ? scan_idx : index;
   assign mbus.wr_en = clk_en && (iwrite_go || rwrite_go);
   assign mbus.wr_idx = rwrite_go ? random : index;
   assign mbus.wr_data = '{mask: pmask, vpn2: entry_hi_vpn2, lo_even: lo_even,
                          lo_odd: lo_odd};

   tlbc_mem u_mem (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .mp(mbus.mem)
   );

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (probe_instr) begin
               next_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (finish) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_comb begin
      if (reg_num == REG_INDEX) begin
         next_rdata = {probe_fail, 26'h000_0000, index};
      end else if (reg_num == REG_RANDOM) begin
         next_rdata = {27'h000_0000, random};
      end else if (reg_num == REG_LO_EVEN) begin
         next_rdata = lo_even;
      end else if (reg_num == REG_LO_ODD) begin
         next_rdata = lo_odd;
      end else if (reg_num == REG_CONTEXT) begin
         next_rdata = {ctx_base, ctx_vpn2, 4'h0};
      end else if (reg_num == REG_PMASK) begin
         next_rdata = {13'h0000, pmask, 11'h000};
      end else if (reg_num == REG_WIRED) begin
         next_rdata = {27'h000_0000, wired};
      end else if (reg_num == REG_FAULT) begin
         next_rdata = fault_addr;
      end else if (reg_num == REG_COUNT) begin
         next_rdata = count;
      end else begin
         next_rdata = 32'h0000_0000;
      end
   end

   // Probe scan: one entry issued per cycle, compared one cycle later.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         busy <= 1'b0;
         scan_idx <= '0;
         cmp_idx <= '0;
         cmp_vld <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         busy <= (next_state == ST_SCAN);
         scan_idx <= probe_go ? '0 : (scan_idx == IDX_TOP) ? scan_idx : scan_idx + 5'h01;
         cmp_idx <= scan_idx;
         cmp_vld <= (state == ST_SCAN) && !finish;
      end
   end

   // Enabled edges spent in the running scan, so that a stuck scan is caught.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         scan_cycles <= 6'h00;
      end else if (clk_en) begin
         scan_cycles <= idle ? 6'h00 : scan_cycles + 6'h01;
      end
   end

   // Index and probe result; the probe result wins over a software write.
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (finish) begin
            probe_fail <= !hit;
            if (hit) begin
               index <= cmp_idx;
            end
         end else if (wr_index) begin
            index <= reg_wdata[IDX_W-1:0];
         end
      end
   end

   // Replacement index and wired limit.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wired <= WIRED_RESET;
         random <= RANDOM_RESET;
      end else if (clk_en) begin
         if (wr_wired) begin
            wired <= reg_wdata[IDX_W-1:0];
            random <= IDX_TOP;
         end else if (instr_retire) begin
            random <= dec_random;
         end
      end
   end

   // Entry-low, page mask and context; an entry read wins over a move.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_pend <= 1'b0;
         read_done <= 1'b0;
      end else if (clk_en) begin
         rd_pend <= read_go;
         read_done <= rd_pend;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (rd_pend) begin
            lo_even <= mbus.rd_data.lo_even;
            lo_odd <= mbus.rd_data.lo_odd;
            pmask <= mbus.rd_data.mask;
            read_vpn2 <= mbus.rd_data.vpn2;
         end else begin
            if (wr_lo_even) begin
               lo_even <= reg_wdata;
            end
            if (wr_lo_odd) begin
               lo_odd <= reg_wdata;
            end
            if (wr_pmask) begin
               pmask <= reg_wdata[MASK_LSB+MASK_W-1:MASK_LSB];
            end
         end
         if (wr_context) begin
            ctx_base <= reg_wdata[31:CTX_BASE_LSB];
         end
         if (tlb_miss) begin
            ctx_vpn2 <= fault_vaddr[31:VADDR_VPN2_LSB];
         end
         if (tlb_miss || addr_err) begin
            fault_addr <= fault_vaddr;
         end
      end
   end

   // Cycle timer on the divided master clock tick.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_cnt <= 4'h0;
         count <= COUNT_RESET;
      end else if (clk_en) begin
         div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
         if (wr_count) begin
            count <= reg_wdata;
         end else if (tick) begin
            count <= count + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 32'h0000_0000;
         even_uncached <= 1'b0;
         odd_uncached <= 1'b0;
      end else if (clk_en) begin
         reg_rdata <= next_rdata;
         even_uncached <= (cattr_even == CATTR_UNCACHED);
         odd_uncached <= (cattr_odd == CATTR_UNCACHED);
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   a_random_in_bounds: assert property (random >= wired)
      else $error("replacement index below wired limit");
   a_wired_write_reload: assert property (clk_en && wr_wired |=> random == 5'h1f)
      else $error("wired write did not reload replacement index");
   a_random_decrement: assert property (clk_en && instr_retire && !wr_wired && random > wired
      |=> random == $past(random) - 5'h01)
      else $error("replacement index did not decrement");
   a_random_wrap_top: assert property (clk_en && instr_retire && !wr_wired && random == wired
      |=> random == 5'h1f)
      else $error("replacement index did not reload at limit");
   a_random_write_target: assert property (clk_en && rwrite_go
      |-> mbus.wr_en && mbus.wr_idx == random && mbus.wr_idx >= wired)
      else $error("random write hit wrong entry");
   a_probe_result_flag: assert property (clk_en && finish |=> probe_fail == !$past(hit))
      else $error("probe flag disagrees with compare");
   a_probe_bounded: assert property (scan_cycles <= 6'(ENTRIES + 1))
      else $error("probe scan did not end in time");
   a_probe_hit_index: assert property (clk_en && finish && hit
      |=> index == $past(cmp_idx))
      else $error("probe hit did not load the index");
   a_index_move: assert property (clk_en && wr_index && !finish
      |=> index == $past(reg_wdata[4:0]))
      else $error("index write did not land");
   a_wired_value: assert property (clk_en && wr_wired
      |=> wired == $past(reg_wdata[4:0]))
      else $error("wired limit write did not land");
   a_mask_move: assert property (clk_en && wr_pmask && !rd_pend
      |=> pmask == $past(reg_wdata[18:11]))
      else $error("page mask write did not land");
   a_read_page_pair: assert property (clk_en && rd_pend
      |=> read_vpn2 == $past(mbus.rd_data.vpn2))
      else $error("entry read did not load the page pair number");
   a_base_hold: assert property (clk_en && !wr_context |=> $stable(ctx_base))
      else $error("page-table base changed without a write");
   a_even_uncached: assert property (clk_en && lo_even[5:3] == 3'h2 |=> even_uncached)
      else $error("uncached code not flagged");
   a_read_loads_mask: assert property (clk_en && read_go ##1 clk_en
      |=> pmask == $past(mbus.rd_data.mask) && read_done)
      else $error("entry read did not load page mask");
   a_miss_context: assert property (clk_en && tlb_miss
      |=> ctx_vpn2 == $past(fault_vaddr[31:11]) && fault_addr == $past(fault_vaddr))
      else $error("miss did not capture address");
   a_fault_hold: assert property (clk_en && !tlb_miss && !addr_err
      |=> $stable(fault_addr))
      else $error("faulting address changed without fault");
   a_timer_step: assert property (clk_en && tick && !wr_count
      |=> count == $past(count) + 32'h0000_0001)
      else $error("timer did not step on tick");
   a_index_reserved: assert property (reg_num == REG_INDEX && clk_en
      |=> reg_rdata[30:5] == 26'h000_0000)
      else $error("index reserved bits not zero");

   c_probe_hit: cover property (clk_en && finish && hit);
   c_probe_miss: cover property (clk_en && finish && !hit);
   c_random_reload: cover property (clk_en && instr_retire && below_wired);
   c_timer_wrap: cover property (clk_en && tick && count == 32'hffff_ffff);
   c_random_write: cover property (clk_en && rwrite_go);
endmodule

// ===== verilog/tlbc_pkg.sv
// Constants and types shared by the translation-buffer control registers.
package tlbc_pkg;
   localparam int IDX_W = 5;
   localparam int VPN2_W = 21;
   localparam int MASK_W = 8;
   localparam int BASE_W = 7;
   localparam int ENTRIES = 32;
   localparam logic [4:0] REG_INDEX = 5'h00;
   localparam logic [4:0] REG_RANDOM = 5'h01;
   localparam logic [4:0] REG_LO_EVEN = 5'h02;
   localparam logic [4:0] REG_LO_ODD = 5'h03;
   localparam logic [4:0] REG_CONTEXT = 5'h04;
   localparam logic [4:0] REG_PMASK = 5'h05;
   localparam logic [4:0] REG_WIRED = 5'h06;
   localparam logic [4:0] REG_FAULT = 5'h08;
   localparam logic [4:0] REG_COUNT = 5'h09;
   localparam int PROBE_BIT = 31;
   localparam int CTX_BASE_LSB = 25;
   localparam int CTX_VPN2_LSB = 4;
   localparam int VADDR_VPN2_LSB = 11;
   localparam int MASK_LSB = 11;
   localparam int CATTR_LSB = 3;
   localparam logic [2:0] CATTR_UNCACHED = 3'h2;
   localparam logic [4:0] IDX_TOP = 5'h1f;
   localparam logic [4:0] WIRED_RESET = 5'h00;
   localparam logic [4:0] RANDOM_RESET = 5'h1f;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [1:0] DIV_SEL_8 = 2'h0;
   localparam logic [1:0] DIV_SEL_12 = 2'h1;
   localparam logic [3:0] DIV8_LAST = 4'h7;
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [3:0] DIV16_LAST = 4'hf;
   typedef struct packed {
      logic [MASK_W-1:0] mask;
      logic [VPN2_W-1:0] vpn2;
      logic [31:0] lo_even;
      logic [31:0] lo_odd;
   } tlbc_entry_s;
endpackage

// ===== verilog/tlbc_mem_if.sv
// Port bundle between the register block and the entry memory.
`timescale 1ns/1ps
interface tlbc_mem_if;
   import tlbc_pkg::*;
   logic [IDX_W-1:0] rd_idx;
   tlbc_entry_s rd_data;
   logic wr_en;
   logic [IDX_W-1:0] wr_idx;
   tlbc_entry_s wr_data;
   modport ctrl (output rd_idx, output wr_en, output wr_idx, output wr_data, input rd_data);
   modport mem (input rd_idx, input wr_en, input wr_idx, input wr_data, output rd_data);
endinterface

// ===== verilog/tlbc_mem.sv
// Thirty-two entry translation store with registered read data.
`timescale 1ns/1ps
module tlbc_mem
   import tlbc_pkg::*;
(
   // Clock and enable.
   input wire logic sys_clk,
   input wire logic clk_en,
   // Access port.
   tlbc_mem_if.mem mp
);
   tlbc_entry_s store [ENTRIES];

   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (mp.wr_en) begin
            store[mp.wr_idx] <= mp.wr_data;
         end
         mp.rd_data <= store[mp.rd_idx];
      end
   end
endmodule

// ===== verif/tlbc_pipe_model.sv
// Pipeline model that issues translation-buffer operations to the block.
`timescale 1ns/1ps
module tlbc_pipe_model
   import tlbc_pkg::*;
(
   // Clock.
   input wire logic sys_clk,
   // Operation strobes.
   output logic instr_retire,
   output logic probe_instr,
   output logic entry_read_instr,
   output logic indexed_write_instr,
   output logic random_write_instr,
   output logic [VPN2_W-1:0] entry_hi_vpn2,
   // Block status.
   input wire logic busy,
   input wire logic read_done
);
   initial begin
      instr_retire = 1'b0;
      probe_instr = 1'b0;
      entry_read_instr = 1'b0;
      indexed_write_instr = 1'b0;
      random_write_instr = 1'b0;
      entry_hi_vpn2 = '0;
   end
   // Codes: 0 retire, 1 probe, 2 read, 3 indexed write, 4 random write.
   // The page number is held after the pulse, so a probe sees it steady.
   task automatic issue(input int op, input logic [VPN2_W-1:0] vpn, output bit ok);
      int n;
      n = 0;
      @(negedge sys_clk);
      entry_hi_vpn2 = vpn;
      instr_retire = (op == 0);
      probe_instr = (op == 1);
      entry_read_instr = (op == 2);
      indexed_write_instr = (op == 3);
      random_write_instr = (op == 4);
      @(negedge sys_clk);
      instr_retire = 1'b0;
      probe_instr = 1'b0;
      entry_read_instr = 1'b0;
      indexed_write_instr = 1'b0;
      random_write_instr = 1'b0;
      while ((busy !== 1'b0 || (op == 2 && read_done !== 1'b1)) && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      ok = (n < 40);
   endtask
endmodule

// ===== verif/tlbc_regs_bench.sv
// Self-checking bench for the translation-buffer control registers.
`timescale 1ns/1ps
module tlbc_regs_bench
   import tlbc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] reg_num = 5'h00;
   logic reg_wr = 1'b0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic tlb_miss = 1'b0;
   logic addr_err = 1'b0;
   logic [31:0] fault_vaddr = 32'h0000_0000;
   logic [1:0] div_sel = 2'h0;
   logic [31:0] reg_rdata;
   logic retire, probe, rd_op, iw_op, rw_op, busy, read_done, even_unc, odd_unc;
   logic [VPN2_W-1:0] hi_vpn2;
   logic [VPN2_W-1:0] read_vpn2;
   int errors = 0;
   int n_tests = 0;
   always #5 sys_clk = ~sys_clk;
   tlbc_regs uut (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .reg_num(reg_num),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .instr_retire(retire),
      .probe_instr(probe), .entry_read_instr(rd_op), .indexed_write_instr(iw_op),
      .random_write_instr(rw_op), .entry_hi_vpn2(hi_vpn2), .busy(busy),
      .read_done(read_done), .read_vpn2(read_vpn2), .tlb_miss(tlb_miss),
      .addr_err(addr_err), .fault_vaddr(fault_vaddr), .div_sel(div_sel),
      .even_uncached(even_unc), .odd_uncached(odd_unc));
   tlbc_pipe_model pm (.sys_clk(sys_clk), .instr_retire(retire), .probe_instr(probe),
      .entry_read_instr(rd_op), .indexed_write_instr(iw_op), .random_write_instr(rw_op),
      .entry_hi_vpn2(hi_vpn2), .busy(busy), .read_done(read_done));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wreg(input logic [4:0] n, input logic [31:0] d);
      @(negedge sys_clk);
      reg_num = n;
      reg_wr = 1'b1;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rreg(input logic [4:0] n, output logic [31:0] d);
      @(negedge sys_clk);
      reg_num = n;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
   task automatic op(input int k, input logic [VPN2_W-1:0] v);
      bit ok;
      pm.issue(k, v, ok);
      chk("op_done", 32'h0000_0001, {31'h0, ok});
      if (!ok) begin
         close_out();
      end
   endtask
   task automatic fault(input logic m, input logic a, input logic [31:0] va);
      @(negedge sys_clk);
      tlb_miss = m;
      addr_err = a;
      fault_vaddr = va;
      @(negedge sys_clk);
      tlb_miss = 1'b0;
      addr_err = 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      logic [31:0] r;
      logic [31:0] s;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      srst = 1'b0;
      chk("busy", 32'h0000_0000, {31'h0, busy});
      rreg(REG_RANDOM, r);
      chk("random", 32'h0000_001f, r);
      rreg(REG_WIRED, r);
      chk("wired", 32'h0000_0000, r);
      for (int c = 0; c < 8; c++) begin
         wreg(REG_LO_EVEN, 32'(c) << 3);
         @(negedge sys_clk);
         chk("even_uncached", {31'h0, c == 2}, {31'h0, even_unc});
      end
      wreg(REG_PMASK, 32'h0000_0000);
      wreg(REG_LO_EVEN, 32'h0000_0010);
      wreg(REG_LO_ODD, 32'h0000_0010);
      @(negedge sys_clk);
      chk("odd_uncached", 32'h0000_0001, {31'h0, odd_unc});
      wreg(REG_LO_ODD, 32'h0000_0018);
      @(negedge sys_clk);
      chk("odd_uncached", 32'h0000_0000, {31'h0, odd_unc});
      for (int i = 0; i < 32; i++) begin
         wreg(REG_INDEX, 32'(i));
         op(3, 21'(i + 256));
      end
      wreg(REG_PMASK, 32'h0000_1800);
      wreg(REG_INDEX, 32'h0000_0005);
      op(3, 21'h0_1235);
      wreg(REG_LO_EVEN, 32'h0000_0000);
      wreg(REG_LO_ODD, 32'h0000_0000);
      wreg(REG_PMASK, 32'h0000_0000);
      op(2, 21'h0_0000);
      chk("read_vpn2", 32'h0000_1235, {11'h0, read_vpn2});
      rreg(REG_LO_EVEN, r);
      chk("lo_even", 32'h0000_0010, r);
      rreg(REG_LO_ODD, r);
      chk("lo_odd", 32'h0000_0018, r);
      rreg(REG_PMASK, r);
      chk("pmask", 32'h0000_1800, r);
      wreg(REG_INDEX, 32'h0000_0000);
      op(1, 21'h0_1236);
      rreg(REG_INDEX, r);
      chk("probe_hit", 32'h0000_0005, r);
      op(1, 21'h1_ffff);
      rreg(REG_INDEX, r);
      chk("probe_miss", 32'h0000_0001, {31'h0, r[31]});
      wreg(REG_INDEX, 32'h7fff_ffe7);
      rreg(REG_INDEX, r);
      chk("index_rsvd", 32'h0000_0007, {1'b0, r[30:0]});
      wreg(REG_WIRED, 32'h0000_0003);
      op(4, 21'h0_abcd);
      wreg(REG_INDEX, 32'h0000_001f);
      op(2, 21'h0_0000);
      chk("random_wr", 32'h0000_abcd, {11'h0, read_vpn2});
      wreg(REG_RANDOM, 32'h0000_0000);
      for (int i = 1; i < 30; i++) begin
         op(0, 21'h0_0000);
         rreg(REG_RANDOM, r);
         chk("random", (i == 29) ? 32'h0000_001f : 32'(31 - i), r);
      end
      wreg(REG_CONTEXT, 32'hfe00_0000);
      fault(1'b1, 1'b0, 32'h89ab_cdef);
      rreg(REG_FAULT, r);
      chk("fault", 32'h89ab_cdef, r);
      rreg(REG_CONTEXT, r);
      chk("context", {7'h7f, 21'h11_3579, 4'h0}, r);
      fault(1'b0, 1'b1, 32'h1234_5678);
      rreg(REG_FAULT, r);
      chk("fault", 32'h1234_5678, r);
      rreg(REG_CONTEXT, r);
      chk("context", {7'h7f, 21'h11_3579, 4'h0}, r);
      for (int d = 0; d < 3; d++) begin
         @(negedge sys_clk);
         div_sel = 2'(d);
         wreg(REG_COUNT, 32'hffff_fffd);
         rreg(REG_COUNT, s);
         repeat (48) @(negedge sys_clk);
         chk("ticks", 32'(48 / (8 + 4 * d)), reg_rdata - s);
      end
      close_out();
   end
endmodule
